// ==== rtl/iva_pkg.sv ====
// Package of vector addresses, source order and shared types for the vector block.
package iva_pkg;

    // ------------------------------------------------------------
    // Widths and source count
    // ------------------------------------------------------------
    localparam int ADDR_W   = 13;
    localparam int NUM_SRC  = 20;
    localparam int IDX_W    = 5;

    // ------------------------------------------------------------
    // Vector addresses (program words)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RESET_VEC        = 13'h0000;
    localparam logic [ADDR_W-1:0] IRQ_BASE         = 13'h0002;
    localparam logic [ADDR_W-1:0] BOOT_RESET_ADDR  = 13'h1c00;
    localparam logic [ADDR_W-1:0] VEC_STEP         = 13'h0002;
    localparam logic [ADDR_W-1:0] IDLE_VEC         = 13'h0000;

    // Table offsets of each source, in vector-number order (index 0 = vector 2).
    localparam logic [ADDR_W-1:0] SRC_VEC [NUM_SRC] = '{
        13'h0002, 13'h0004, 13'h0006, 13'h0008, 13'h000a,
        13'h000c, 13'h000e, 13'h0010, 13'h0012, 13'h0014,
        13'h0016, 13'h0018, 13'h001a, 13'h001c, 13'h001e,
        13'h0020, 13'h0022, 13'h0024, 13'h0026, 13'h0028
    };

    // ------------------------------------------------------------
    // Fuse decode and reset values
    // ------------------------------------------------------------
    localparam logic FUSE_UNPROGRAMMED = 1'b1;
    localparam logic FUSE_PROGRAMMED   = 1'b0;
    localparam logic [IDX_W-1:0] IDX_RST = 5'h00;

    // ------------------------------------------------------------
    // Source request bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic program_store_ready;
        logic counter0_compare;
        logic ext_request_2;
        logic two_wire_event;
        logic analog_comparator_event;
        logic eeprom_ready;
        logic adc_complete;
        logic transmit_complete;
        logic tx_data_empty;
        logic receive_complete;
        logic serial_transfer_done;
        logic counter0_overflow;
        logic counter1_overflow;
        logic counter1_compare_b;
        logic counter1_compare_a;
        logic counter1_capture;
        logic counter2_overflow;
        logic counter2_compare;
        logic ext_request_1;
        logic ext_request_0;
    } iva_req_type;

    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  idx;
    } iva_pick_type;

endpackage

// ==== rtl/iva_prio.sv ====
// Fixed-priority picker: lowest set request index wins.
`timescale 1ns/10ps
module iva_prio #(
    parameter int N = 20,
    parameter int W = 5
) (
    input  wire logic [N-1:0]  req,
    output iva_pkg::iva_pick_type pick
);

    always_comb begin
        pick = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                pick.valid = 1'b1;
                pick.idx   = W'(i);
            end
        end
    end

endmodule

// ==== rtl/iva_vector.sv ====
// Reset and interrupt vector address generator for the processor core.
// What this block does
// [R1] With the fuse unprogrammed, reset starts at word zero.
// [R2] External requests vector to 002, 004, 024.
// [R3] Timer events vector to their fixed words.
// [R4] Serial events vector to their fixed words.
// [R5] ADC, EEPROM, comparator, store-ready fixed vectors.
// [R6] Programmed boot fuse starts at boot address.
// [R7] Vector select adds boot section start.
// [R8] Vector base independent of reset target.
// [R9] Fuse one unprogrammed, zero programmed.
// [R10] Boot section start is word 1C00.
// [R11] Lowest pending vector number served first.
`timescale 1ns/10ps
module iva_vector #(
    parameter logic [iva_pkg::ADDR_W-1:0] BOOT_ADDR = iva_pkg::BOOT_RESET_ADDR
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         boot_reset_fuse,
    input  wire logic                         vector_select_boot,
    input  wire iva_pkg::iva_req_type         irq_req,
    input  wire logic                         irq_ack,
    output logic                              reset_fetch,
    output logic [iva_pkg::ADDR_W-1:0]        reset_addr,
    output logic                              irq_pending,
    output logic [iva_pkg::ADDR_W-1:0]        irq_addr,
    output logic [iva_pkg::IDX_W-1:0]         irq_index,
    output logic                              irq_taken
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                        fuse_sync0;
        logic                        fuse_sync1;
        logic                        fuse_seen;
        logic                        rst_fetch;
        logic [iva_pkg::ADDR_W-1:0]  rst_addr;
        logic                        pend;
        logic [iva_pkg::ADDR_W-1:0]  vec;
        logic [iva_pkg::IDX_W-1:0]   idx;
        logic                        taken;
    } iva_state_type;

    iva_state_type                st_r;
    iva_state_type                st_nxt;
    iva_pkg::iva_pick_type        pick;
    logic [iva_pkg::NUM_SRC-1:0]  req_vec;
    logic                         fuse_prog;
    logic [iva_pkg::ADDR_W-1:0]   boot_target;
    logic                         idx_ok;
    logic [iva_pkg::ADDR_W-1:0]   tbl_addr;
    logic [iva_pkg::ADDR_W-1:0]   vec_base;
    logic [iva_pkg::ADDR_W-1:0]   vec_sum;

    // ------------------------------------------------------------
    // Request map
    // ------------------------------------------------------------
    // Bit k of the picker input is the source at vector number k plus two, so the
    // field order of the request bundle never decides the priority.
    // External requests and timers.
    assign req_vec[0]  = irq_req.ext_request_0;              // [R2]
    assign req_vec[1]  = irq_req.ext_request_1;              // [R2]
    assign req_vec[2]  = irq_req.counter2_compare;           // [R3]
    assign req_vec[3]  = irq_req.counter2_overflow;          // [R3]
    assign req_vec[4]  = irq_req.counter1_capture;           // [R3]
    assign req_vec[5]  = irq_req.counter1_compare_a;         // [R3]
    assign req_vec[6]  = irq_req.counter1_compare_b;         // [R3]
    assign req_vec[7]  = irq_req.counter1_overflow;          // [R3]
    assign req_vec[8]  = irq_req.counter0_overflow;          // [R3]

    // Serial units.
    assign req_vec[9]  = irq_req.serial_transfer_done;       // [R4]
    assign req_vec[10] = irq_req.receive_complete;           // [R4]
    assign req_vec[11] = irq_req.tx_data_empty;              // [R4]
    assign req_vec[12] = irq_req.transmit_complete;          // [R4]

    // Converter, memory, comparator and the late table entries.
    assign req_vec[13] = irq_req.adc_complete;               // [R5]
    assign req_vec[14] = irq_req.eeprom_ready;               // [R5]
    assign req_vec[15] = irq_req.analog_comparator_event;    // [R5]
    assign req_vec[16] = irq_req.two_wire_event;             // [R4]
    assign req_vec[17] = irq_req.ext_request_2;              // [R2]
    assign req_vec[18] = irq_req.counter0_compare;           // [R3]
    assign req_vec[19] = irq_req.program_store_ready;        // [R5]

    // ------------------------------------------------------------
    // Reset target
    // ------------------------------------------------------------
    // The strap is read from the second synchroniser stage only.
    assign fuse_prog   = (st_r.fuse_sync1 == iva_pkg::FUSE_PROGRAMMED);    // [R9]
    assign boot_target = fuse_prog ? BOOT_ADDR : iva_pkg::RESET_VEC;       // [R1] [R6] [R10]

    // ------------------------------------------------------------
    // Vector address
    // ------------------------------------------------------------
    // The base moves with the select bit alone; the fuse never enters here.
    assign idx_ok   = (32'(pick.idx) < 32'(iva_pkg::NUM_SRC));
    assign tbl_addr = idx_ok ? iva_pkg::SRC_VEC[pick.idx] : iva_pkg::IDLE_VEC;
    assign vec_base = vector_select_boot ? BOOT_ADDR : '0;                 // [R7] [R8]
    assign vec_sum  = tbl_addr + vec_base;                                 // [R7]

    // ------------------------------------------------------------
    // Picker
    // ------------------------------------------------------------
    iva_prio #(
        .N (iva_pkg::NUM_SRC),
        .W (iva_pkg::IDX_W)
    ) u_prio (
        .req  (req_vec),
        .pick (pick)    // [R11]
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // The strap passes two stages before anything reads it.
        st_nxt.fuse_sync0 = boot_reset_fuse;
        st_nxt.fuse_sync1 = st_r.fuse_sync0;

        // The reset target is decided once, on the first edge after release.
        st_nxt.fuse_seen = 1'b1;
        st_nxt.rst_fetch = 1'b0;
        if (!st_r.fuse_seen) begin
            st_nxt.rst_fetch = 1'b1;                          // [R1]
            st_nxt.rst_addr  = boot_target;                   // [R6] [R9]
        end

        // The offered vector is rebuilt every cycle from the live requests.
        st_nxt.pend = pick.valid;                             // [R11]
        if (pick.valid) begin
            st_nxt.idx = pick.idx;                            // [R11]
            st_nxt.vec = vec_sum;                             // [R7] [R8]
        end else begin
            st_nxt.vec = iva_pkg::IDLE_VEC;
            st_nxt.idx = iva_pkg::IDX_RST;
        end

        // One pulse for each cycle in which the core takes the offer.
        st_nxt.taken = st_r.pend && irq_ack;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // The strap stages keep running so that the fuse has settled at release.
            st_r.fuse_sync0 <= st_nxt.fuse_sync0;
            st_r.fuse_sync1 <= st_nxt.fuse_sync1;
            st_r.fuse_seen  <= 1'b0;
            st_r.rst_fetch  <= 1'b0;
            st_r.rst_addr   <= iva_pkg::RESET_VEC;
            st_r.pend       <= 1'b0;
            st_r.vec        <= iva_pkg::IDLE_VEC;
            st_r.idx        <= iva_pkg::IDX_RST;
            st_r.taken      <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reset_fetch = st_r.rst_fetch;
    assign reset_addr  = st_r.rst_addr;
    assign irq_pending = st_r.pend;
    assign irq_addr    = st_r.vec;
    assign irq_index   = st_r.idx;
    assign irq_taken   = st_r.taken;

endmodule

// ==== testbench/iva_vector_checker.sv ====
// Assertion checker bound to the vector block ports.
`timescale 1ns/10ps
module iva_vector_checker #(parameter logic [12:0] BOOT_ADDR = 13'h1c00) (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire logic                 boot_reset_fuse,
    input wire logic                 vector_select_boot,
    input wire iva_pkg::iva_req_type irq_req,
    input wire logic                 irq_ack,
    input wire logic                 reset_fetch,
    input wire logic [12:0]          reset_addr,
    input wire logic                 irq_pending,
    input wire logic [12:0]          irq_addr,
    input wire logic [4:0]           irq_index,
    input wire logic                 irq_taken
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_fetch; reset_fetch |=> !reset_fetch; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch too long");
    property p_rzero;
        reset_fetch && $past(boot_reset_fuse, 3) |-> reset_addr == 13'h0000;
    endproperty
    a_rzero: assert property (p_rzero) else $error("reset addr");
    property p_rboot;
        reset_fetch && !$past(boot_reset_fuse, 3) |-> reset_addr == BOOT_ADDR;
    endproperty
    a_rboot: assert property (p_rboot) else $error("boot addr");
    property p_hold; !reset_fetch && $past(nrst) |-> $stable(reset_addr); endproperty
    a_hold: assert property (p_hold) else $error("reset addr moved");
    property p_vec;
        irq_pending |-> irq_addr == 13'h0002 + {irq_index, 1'b0}
            + ($past(vector_select_boot) ? BOOT_ADDR : 13'h0000);
    endproperty
    a_vec: assert property (p_vec) else $error("vector addr");
    property p_low;
        irq_pending |-> (20'h1 << irq_index) == ($past(irq_req) & -$past(irq_req));
    endproperty
    a_low: assert property (p_low) else $error("priority");
    property p_pend; irq_req != '0 |=> irq_pending; endproperty
    a_pend: assert property (p_pend) else $error("no pending");
    property p_take; irq_pending && irq_ack |=> irq_taken; endproperty
    a_take: assert property (p_take) else $error("no taken");
endmodule
bind iva_vector iva_vector_checker #(.BOOT_ADDR(BOOT_ADDR)) iva_vector_checker_i (.*);

// ==== testbench/iva_core_model.sv ====
// Core model that takes an offered vector after a chosen wait.
`timescale 1ns/10ps
module iva_core_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [1:0]  wait_n,
    input  wire logic        irq_pending,
    input  wire logic [12:0] irq_addr,
    output logic             irq_ack,
    output logic [12:0]      fetched
);
    logic [1:0] cnt;
    always @(posedge clk) begin
        cnt <= (nrst && irq_pending && !irq_ack) ? cnt + 2'h1 : 2'h0;
        irq_ack <= nrst && irq_pending && !irq_ack && cnt >= wait_n;
        if (nrst && irq_pending && !irq_ack && cnt >= wait_n) fetched <= irq_addr;
    end
endmodule

// ==== testbench/tb_iva_vector.sv ====
// Testbench of the vector block with a core model.
`timescale 1ns/10ps
module tb_iva_vector;
    logic clk, nrst, boot_reset_fuse, vector_select_boot, irq_ack;
    logic reset_fetch, irq_pending, irq_taken;
    iva_pkg::iva_req_type irq_req;
    logic [12:0] reset_addr, irq_addr, fetched;
    logic [4:0]  irq_index;
    logic [1:0]  wait_n;
    int          miscompares = 0;
    int          cmp_count = 0;
    iva_vector iva_vector_i (.*);
    iva_core_model iva_core_model_i (.*);
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_reset(input logic fuse, input logic [12:0] exp);
        int n;
        @(negedge clk);
        nrst = 0;
        boot_reset_fuse = fuse;
        repeat (3) @(negedge clk);
        nrst = 1;
        for (n = 0; n < 4 && reset_fetch !== 1'b1; n++) @(negedge clk);
        chk({12'h0, reset_fetch}, 13'h1);
        chk(reset_addr, exp);
        boot_reset_fuse = !fuse;
        repeat (2) @(negedge clk);
        chk({12'h0, reset_fetch}, 13'h0);
        chk(reset_addr, exp);
    endtask
    task automatic t_each(input logic vsel);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            vector_select_boot = vsel;
            irq_req = 20'h1 << i;
            @(negedge clk);
            chk(irq_addr, 13'h0002 + 13'(2 * i) + (vsel ? 13'h1c00 : 13'h0));
            chk({8'h0, irq_index}, 13'(i));
            chk({12'h0, irq_pending}, 13'h1);
            irq_req = '0;
        end
    endtask
    task automatic t_prio;
        int n;
        wait_n = 2'h2;
        @(negedge clk);
        irq_req = 20'h80024;
        for (n = 0; n < 10 && irq_taken !== 1'b1; n++) @(negedge clk);
        chk({12'h0, irq_taken}, 13'h1);
        chk(fetched, 13'h1c06);
        irq_req = 20'h80000;
        repeat (2) @(negedge clk);
        chk(irq_addr, 13'h1c28);
        vector_select_boot = 1'b0;
        @(negedge clk);
        chk(irq_addr, 13'h0028);
        irq_req = '0;
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (400) @(posedge clk);
        miscompares++;
        results;
    end
    initial begin
        nrst = 0;
        boot_reset_fuse = 1;
        vector_select_boot = 0;
        irq_req = '0;
        wait_n = 2'h0;
        t_reset(1'b1, 13'h0000);
        t_each(1'b0);
        t_each(1'b1);
        t_reset(1'b0, 13'h1c00);
        t_prio;
        results;
    end
endmodule
